// file: verilog/fwu_defs.svh
// Behaviour
// - ignore write strobes shorter than 5 ns
// - output enable low blocks every write
// - unlock protection always on, never bypassed
// - sequences open AA@5555, 55@2AAA, cmd@5555
// - program is unlock with A0, then data
// - fourth write gives program address and data
// - erase needs six writes, 80 then AA/55
// - sixth write 30 selects sector erase
// - sixth write 50 selects block erase
// - chip erase 10@5555 in parallel mode only
// - unlock with 90 enters identification mode
// - F0 single or unlocked leaves identification
// - identification mode cleared by reset
// - mismatched write aborts sequence to read mode
// - sequence steps are consecutive cycles in parallel mode
// - command addresses compare bits 14 to 0
// - writes ignored while operation runs
// - top status bit complement or zero while busy
// - next status bit alternates per busy read
`ifndef FWU_DEFS_SVH
`define FWU_DEFS_SVH
`define FWU_ADDR_W 22
`define FWU_CMD_MSB 14
`define FWU_CMD_W 15
`define FWU_ADDR_UNLOCK1 15'h5555
`define FWU_ADDR_UNLOCK2 15'h2AAA
`define FWU_DAT_UNLOCK1 8'hAA
`define FWU_DAT_UNLOCK2 8'h55
`define FWU_DAT_PROGRAM 8'hA0
`define FWU_DAT_ERASE 8'h80
`define FWU_DAT_ID_ENTRY 8'h90
`define FWU_DAT_ID_EXIT 8'hF0
`define FWU_DAT_SECTOR 8'h30
`define FWU_DAT_BLOCK 8'h50
`define FWU_DAT_CHIP 8'h10
`define FWU_LEN_PROGRAM 3'h4
`define FWU_LEN_ERASE 3'h6
`define FWU_LEN_UNLOCK 3'h3
`define FWU_LEN_SHORT 3'h1
`define FWU_GLITCH_PS 5000
`define FWU_CLK_PS 5000
`define FWU_HOST_STROBE_CYC 2
`define FWU_TOP_BIT 7
`define FWU_TOGGLE_BIT 6
`endif

// file: verilog/fwu_pkg.sv
package fwu_pkg;
  typedef enum logic [1:0] {OP_PROGRAM, OP_SECTOR, OP_BLOCK, OP_CHIP} fwu_op_t;
  typedef enum logic [2:0] {
    CMD_PROGRAM, CMD_SECTOR, CMD_BLOCK, CMD_CHIP,
    CMD_ID_ENTRY, CMD_ID_EXIT, CMD_ID_EXIT_SHORT, CMD_READ
  } fwu_cmd_t;
  typedef enum logic [3:0] {
    S_IDLE, S_UNLK1, S_UNLK2, S_PGM, S_ERS3, S_ERS4, S_ERS5, S_BUSY
  } fwu_state_t;
  typedef enum logic [1:0] {H_IDLE, H_LOW, H_HIGH, H_READ} fwu_hstate_t;
endpackage

// file: verilog/fwu_if.sv
`timescale 1ns/1ps
`include "fwu_defs.svh"
interface fwu_if;
  logic writeStrobeN;
  logic outEnableN;
  logic [`FWU_ADDR_W-1:0] addr;
  logic [7:0] wdata;
  logic rdReq;
  logic rdValid;
  logic [7:0] rdData;
  modport device (
    input writeStrobeN, outEnableN, addr, wdata, rdReq,
    output rdValid, rdData
  );
  modport host (
    output writeStrobeN, outEnableN, addr, wdata, rdReq,
    input rdValid, rdData
  );
endinterface

// file: verilog/fwu_device.sv
`timescale 1ns/1ps
`include "fwu_defs.svh"
module fwu_device #(
  parameter logic [7:0] MFR_ID = 8'h3C, // arbitrary value
  parameter logic [7:0] DEV_ID = 8'hC3  // arbitrary value
) (
  input wire logic clk,
  input wire logic reset_n,
  fwu_if.device bus,
  input wire logic parallelMode,
  output logic [`FWU_ADDR_W-1:0] arrayAddr,
  input wire logic [7:0] arrayRdData,
  input wire logic engineDone,
  output logic opStart,
  output fwu_pkg::fwu_op_t opKind,
  output logic [`FWU_ADDR_W-1:0] opAddr,
  output logic [7:0] opData,
  output logic busy,
  output logic idMode
);
  import fwu_pkg::*;

  localparam int GlitchCycRaw = (`FWU_GLITCH_PS + `FWU_CLK_PS - 1) / `FWU_CLK_PS;
  localparam int GlitchCyc = (GlitchCycRaw < 1) ? 1 : GlitchCycRaw;
  localparam logic [7:0] GlitchCnt = 8'(GlitchCyc);

  fwu_state_t state_q, state_d;
  logic idMode_q, idMode_d;
  logic opStart_q, opStart_d;
  fwu_op_t opKind_q, opKind_d;
  logic [`FWU_ADDR_W-1:0] opAddr_q, opAddr_d;
  logic [7:0] opData_q, opData_d;
  logic [7:0] lowCnt_q, lowCnt_d;
  logic inhibit_q;
  logic toggle_q;
  logic rdValid_q;
  logic [7:0] rdData_q, rdData_d;

  wire strobeLow = ~bus.writeStrobeN;
  wire [`FWU_CMD_W-1:0] cmdAddr = bus.addr[`FWU_CMD_MSB:0];
  wire isAddr1 = (cmdAddr == `FWU_ADDR_UNLOCK1);
  wire isAddr2 = (cmdAddr == `FWU_ADDR_UNLOCK2);
  wire step1Ok = isAddr1 && (bus.wdata == `FWU_DAT_UNLOCK1);
  wire step2Ok = isAddr2 && (bus.wdata == `FWU_DAT_UNLOCK2);
  // write taken on strobe release, only after a long enough low phase
  wire pulseLong = (lowCnt_q >= GlitchCnt);
  wire wrCommit = bus.writeStrobeN && (lowCnt_q != 8'h00) && pulseLong &&
                  !inhibit_q && bus.outEnableN;
  wire inSequence = (state_q != S_IDLE) && (state_q != S_BUSY);
  // parallel mode: an intervening read cycle breaks the sequence
  wire rdBreak = bus.rdReq && parallelMode && inSequence;
  wire isBusy = (state_q == S_BUSY);
  wire busyPgm = isBusy && (opKind_q == OP_PROGRAM);
  wire topStatus = busyPgm ? ~opData_q[`FWU_TOP_BIT] : 1'b0;
  wire idByte = bus.addr[0];

  assign lowCnt_d = !strobeLow ? 8'h00 :
                    (lowCnt_q == GlitchCnt) ? lowCnt_q : lowCnt_q + 8'h01;

  always_comb begin
    state_d = state_q;
    idMode_d = idMode_q;
    opStart_d = 1'b0;
    opKind_d = opKind_q;
    opAddr_d = opAddr_q;
    opData_d = opData_q;
    if (rdBreak) begin
      state_d = S_IDLE;
    end else if (isBusy) begin
      // writes ignored until the operation ends
      if (engineDone) begin
        state_d = S_IDLE;
      end
    end else if (wrCommit) begin
      // every mismatch below falls back to idle at once
      state_d = S_IDLE;
      case (state_q)
        S_IDLE: begin
          if (step1Ok) begin
            state_d = S_UNLK1;
          end else if (bus.wdata == `FWU_DAT_ID_EXIT) begin
            idMode_d = 1'b0;
          end
        end
        S_UNLK1: begin
          if (step2Ok) begin
            state_d = S_UNLK2;
          end
        end
        S_UNLK2: begin
          if (isAddr1) begin
            case (bus.wdata)
              `FWU_DAT_PROGRAM: state_d = S_PGM;
              `FWU_DAT_ERASE: state_d = S_ERS3;
              `FWU_DAT_ID_ENTRY: idMode_d = 1'b1;
              `FWU_DAT_ID_EXIT: idMode_d = 1'b0;
              default: state_d = S_IDLE;
            endcase
          end
        end
        S_PGM: begin
          opKind_d = OP_PROGRAM;
          opAddr_d = bus.addr;
          opData_d = bus.wdata;
          opStart_d = 1'b1;
          state_d = S_BUSY;
        end
        S_ERS3: begin
          if (step1Ok) begin
            state_d = S_ERS4;
          end
        end
        S_ERS4: begin
          if (step2Ok) begin
            state_d = S_ERS5;
          end
        end
        S_ERS5: begin
          if (bus.wdata == `FWU_DAT_SECTOR) begin
            opKind_d = OP_SECTOR;
            opStart_d = 1'b1;
            state_d = S_BUSY;
          end else if (bus.wdata == `FWU_DAT_BLOCK) begin
            opKind_d = OP_BLOCK;
            opStart_d = 1'b1;
            state_d = S_BUSY;
          end else if (bus.wdata == `FWU_DAT_CHIP && isAddr1 && parallelMode) begin
            opKind_d = OP_CHIP;
            opStart_d = 1'b1;
            state_d = S_BUSY;
          end
          // op fields move only when the erase is accepted
          if (opStart_d) begin
            opAddr_d = bus.addr;
            opData_d = bus.wdata;
          end
        end
        default: state_d = S_IDLE;
      endcase
    end
  end
  always_comb begin
    if (isBusy) begin
      rdData_d = {topStatus, toggle_q, arrayRdData[`FWU_TOGGLE_BIT-1:0]};
    end else if (idMode_q) begin
      rdData_d = idByte ? DEV_ID : MFR_ID;
    end else begin
      rdData_d = arrayRdData;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_q <= S_IDLE;
      idMode_q <= 1'b0;
      opStart_q <= 1'b0;
      opKind_q <= OP_PROGRAM;
      opAddr_q <= '0;
      opData_q <= 8'h00;
    end else begin
      state_q <= state_d;
      idMode_q <= idMode_d;
      opStart_q <= opStart_d;
      opKind_q <= opKind_d;
      opAddr_q <= opAddr_d;
      opData_q <= opData_d;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      lowCnt_q <= 8'h00;
      inhibit_q <= 1'b0;
    end else begin
      lowCnt_q <= lowCnt_d;
      inhibit_q <= strobeLow && (inhibit_q || !bus.outEnableN);
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      toggle_q <= 1'b0;
      rdValid_q <= 1'b0;
      rdData_q <= 8'h00;
    end else begin
      rdValid_q <= bus.rdReq;
      if (bus.rdReq) begin
        rdData_q <= rdData_d;
      end
      if (opStart_d) begin
        toggle_q <= 1'b0;
      end else if (bus.rdReq && isBusy) begin
        toggle_q <= ~toggle_q;
      end
    end
  end

  assign bus.rdValid = rdValid_q;
  assign bus.rdData = rdData_q;
  assign arrayAddr = bus.addr;
  assign opStart = opStart_q;
  assign opKind = opKind_q;
  assign opAddr = opAddr_q;
  assign opData = opData_q;
  assign busy = isBusy;
  assign idMode = idMode_q;
endmodule

// file: verilog/fwu_host.sv
`timescale 1ns/1ps
`include "fwu_defs.svh"
module fwu_host #(
  parameter int STROBE_CYC = `FWU_HOST_STROBE_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  fwu_if.host bus,
  input wire logic cmdValid,
  output logic cmdReady,
  input wire fwu_pkg::fwu_cmd_t cmdKind,
  input wire logic [`FWU_ADDR_W-1:0] cmdAddr,
  input wire logic [7:0] cmdData,
  output logic rdDone,
  output logic [7:0] rdDoneData
);
  import fwu_pkg::*;

  localparam logic [7:0] StrobeCnt = 8'(STROBE_CYC);

  fwu_hstate_t state_q;
  fwu_cmd_t kind_q;
  logic [`FWU_ADDR_W-1:0] uAddr_q, addr_q;
  logic [7:0] uData_q, wdata_q;
  logic [2:0] step_q, len_q;
  logic [7:0] cnt_q;
  logic strobeN_q, oeN_q, rdReq_q, rdDone_q;
  logic [7:0] rdDoneData_q;

  function automatic logic [`FWU_ADDR_W+7:0] stepWord(
    input fwu_cmd_t k, input logic [2:0] s,
    input logic [`FWU_ADDR_W-1:0] ua, input logic [7:0] ud);
    logic [`FWU_ADDR_W-1:0] a1, a2;
    logic [7:0] c3, c6;
    a1 = `FWU_ADDR_W'(`FWU_ADDR_UNLOCK1);
    a2 = `FWU_ADDR_W'(`FWU_ADDR_UNLOCK2);
    c3 = (k == CMD_PROGRAM) ? `FWU_DAT_PROGRAM :
         (k == CMD_ID_ENTRY) ? `FWU_DAT_ID_ENTRY :
         (k == CMD_ID_EXIT) ? `FWU_DAT_ID_EXIT : `FWU_DAT_ERASE;
    c6 = (k == CMD_SECTOR) ? `FWU_DAT_SECTOR :
         (k == CMD_BLOCK) ? `FWU_DAT_BLOCK : `FWU_DAT_CHIP;
    case (s)
      3'h0: stepWord = (k == CMD_ID_EXIT_SHORT) ? {ua, `FWU_DAT_ID_EXIT} :
                       {a1, `FWU_DAT_UNLOCK1};
      3'h1: stepWord = {a2, `FWU_DAT_UNLOCK2};
      3'h2: stepWord = {a1, c3};
      3'h3: stepWord = (k == CMD_PROGRAM) ? {ua, ud} : {a1, `FWU_DAT_UNLOCK1};
      3'h4: stepWord = {a2, `FWU_DAT_UNLOCK2};
      3'h5: stepWord = (k == CMD_CHIP) ? {a1, c6} : {ua, c6};
      default: stepWord = {a1, `FWU_DAT_UNLOCK1};
    endcase
  endfunction

  wire [2:0] cmdLen = (cmdKind == CMD_PROGRAM) ? `FWU_LEN_PROGRAM :
                      (cmdKind == CMD_ID_EXIT_SHORT) ? `FWU_LEN_SHORT :
                      (cmdKind == CMD_ID_ENTRY || cmdKind == CMD_ID_EXIT) ?
                      `FWU_LEN_UNLOCK : `FWU_LEN_ERASE;
  wire [`FWU_ADDR_W+7:0] firstWord = stepWord(cmdKind, 3'h0, cmdAddr, cmdData);
  wire [2:0] nextStep = step_q + 3'h1;
  wire [`FWU_ADDR_W+7:0] nextWord = stepWord(kind_q, nextStep, uAddr_q, uData_q);
  wire lastStep = (nextStep == len_q);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_q <= H_IDLE;
      kind_q <= CMD_READ;
      uAddr_q <= '0;
      uData_q <= 8'h00;
      addr_q <= '0;
      wdata_q <= 8'h00;
      step_q <= 3'h0;
      len_q <= 3'h0;
      cnt_q <= 8'h00;
      strobeN_q <= 1'b1;
      oeN_q <= 1'b1;
      rdReq_q <= 1'b0;
      rdDone_q <= 1'b0;
      rdDoneData_q <= 8'h00;
    end else begin
      rdDone_q <= 1'b0;
      rdReq_q <= 1'b0;
      case (state_q)
        H_IDLE: begin
          if (cmdValid && cmdKind == CMD_READ) begin
            addr_q <= cmdAddr;
            oeN_q <= 1'b0;
            rdReq_q <= 1'b1;
            state_q <= H_READ;
          end else if (cmdValid) begin
            kind_q <= cmdKind;
            uAddr_q <= cmdAddr;
            uData_q <= cmdData;
            len_q <= cmdLen;
            step_q <= 3'h0;
            {addr_q, wdata_q} <= firstWord;
            strobeN_q <= 1'b0;
            cnt_q <= 8'h01;
            state_q <= H_LOW;
          end
        end
        H_LOW: begin
          if (cnt_q >= StrobeCnt) begin
            strobeN_q <= 1'b1;
            state_q <= H_HIGH;
          end else begin
            cnt_q <= cnt_q + 8'h01;
          end
        end
        H_HIGH: begin
          if (lastStep) begin
            state_q <= H_IDLE;
          end else begin
            // next step follows straight on, no other cycle between
            step_q <= nextStep;
            {addr_q, wdata_q} <= nextWord;
            strobeN_q <= 1'b0;
            cnt_q <= 8'h01;
            state_q <= H_LOW;
          end
        end
        H_READ: begin
          if (bus.rdValid) begin
            rdDoneData_q <= bus.rdData;
            rdDone_q <= 1'b1;
            oeN_q <= 1'b1;
            state_q <= H_IDLE;
          end
        end
        default: state_q <= H_IDLE;
      endcase
    end
  end

  assign cmdReady = (state_q == H_IDLE);
  assign bus.writeStrobeN = strobeN_q;
  assign bus.outEnableN = oeN_q;
  assign bus.addr = addr_q;
  assign bus.wdata = wdata_q;
  assign bus.rdReq = rdReq_q;
  assign rdDone = rdDone_q;
  assign rdDoneData = rdDoneData_q;
endmodule

// file: tb/fwu_checker.sv
`timescale 1ns/1ps
`include "fwu_defs.svh"
module fwu_checker (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic writeStrobeN,
  input wire logic outEnableN,
  input wire logic [`FWU_ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic rdReq,
  input wire logic rdValid,
  input wire logic [7:0] rdData
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  rd_answer_a: assert property (rdReq |=> rdValid)
    else $error("read not answered next cycle");
  rd_pulse_a: assert property (rdValid |=> !rdValid)
    else $error("read answer longer than one cycle");
  rd_cause_a: assert property (rdValid |-> $past(rdReq))
    else $error("read answer without request");
  rd_hold_a: assert property ($changed(rdData) |-> rdValid)
    else $error("read data moved between reads");
  strobe_width_a: assert property ($fell(writeStrobeN) |=> !writeStrobeN)
    else $error("write strobe too short");
  inhibit_write_a: assert property (!writeStrobeN |-> outEnableN)
    else $error("strobe low with output enable low");
  read_no_write_a: assert property (rdReq |-> writeStrobeN && !outEnableN)
    else $error("read overlaps a write");
  addr_stable_a: assert property (!$past(writeStrobeN) |-> $stable(addr) && $stable(wdata))
    else $error("address or data moved within a write");
  cover property (rdValid);
  cover property ($rose(writeStrobeN));
  cover property (rdValid && rdData[6]);
endmodule

// file: tb/flash_write_unlock_decoder_tb.sv
`timescale 1ns/1ps
`include "fwu_defs.svh"
module flash_write_unlock_decoder_tb;
  import fwu_pkg::*;
  localparam logic [7:0] MFR = 8'h3C; // arbitrary value
  localparam logic [7:0] DEV = 8'hC3; // arbitrary value
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic parallelMode = 1'b0;
  logic [7:0] arrayRdData = 8'h2D;
  logic engineDone = 1'b0;
  logic cmdValid = 1'b0;
  fwu_cmd_t cmdKind = CMD_READ;
  logic [`FWU_ADDR_W-1:0] cmdAddr = '0;
  logic [7:0] cmdData = 8'h00;
  logic cmdReady, rdDone, opStart, busy, idMode, opStartB;
  logic [7:0] rdDoneData, opData;
  logic [`FWU_ADDR_W-1:0] opAddr;
  logic [`FWU_ADDR_W-1:0] arrayAddr;
  fwu_op_t opKind;
  int fails = 0;
  int check_count = 0;
  int ops = 0;
  int opsB = 0;
  int rds = 0;
  fwu_if bus();
  fwu_if busB();
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    if (opStart === 1'b1) ops <= ops + 1;
    if (opStartB === 1'b1) opsB <= opsB + 1;
    if (rdDone === 1'b1) rds <= rds + 1;
  end
  fwu_host i_fwu_host (.clk(clk), .reset_n(reset_n), .bus(bus.host), .cmdValid(cmdValid),
    .cmdReady(cmdReady), .cmdKind(cmdKind), .cmdAddr(cmdAddr), .cmdData(cmdData),
    .rdDone(rdDone), .rdDoneData(rdDoneData));
  fwu_device #(.MFR_ID(MFR), .DEV_ID(DEV)) i_fwu_device (.clk(clk), .reset_n(reset_n),
    .bus(bus.device), .parallelMode(parallelMode), .arrayAddr(arrayAddr),
    .arrayRdData(arrayRdData), .engineDone(engineDone), .opStart(opStart), .opKind(opKind),
    .opAddr(opAddr),
    .opData(opData), .busy(busy), .idMode(idMode));
  // second device faces a bench driver that breaks the protocol on purpose
  fwu_device #(.MFR_ID(MFR), .DEV_ID(DEV)) i_fwu_device_b (.clk(clk), .reset_n(reset_n),
    .bus(busB.device), .parallelMode(parallelMode), .arrayAddr(), .arrayRdData(arrayRdData),
    .engineDone(engineDone), .opStart(opStartB), .opKind(), .opAddr(), .opData(), .busy(),
    .idMode());
  fwu_checker i_fwu_checker (.clk(clk), .reset_n(reset_n), .writeStrobeN(bus.writeStrobeN),
    .outEnableN(bus.outEnableN), .addr(bus.addr), .wdata(bus.wdata), .rdReq(bus.rdReq),
    .rdValid(bus.rdValid), .rdData(bus.rdData));
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask
  task end_of_test;
    $display("checks=%0d fails=%0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task do_reset;
    @(posedge clk) reset_n <= 1'b0;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    @(negedge clk);
  endtask
  task cmd(input fwu_cmd_t k, input logic [`FWU_ADDR_W-1:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cmdValid <= 1'b1;
    cmdKind <= k;
    cmdAddr <= a;
    cmdData <= d;
    @(posedge clk);
    cmdValid <= 1'b0;
    @(negedge clk);
    while (cmdReady !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    if (n == 200) fails++;
    repeat (2) @(negedge clk);
  endtask
  task done;
    @(posedge clk) engineDone <= 1'b1;
    @(posedge clk) engineDone <= 1'b0;
    repeat (2) @(negedge clk);
  endtask
  task wr(input logic [`FWU_ADDR_W-1:0] a, input logic [7:0] d, input logic oe);
    @(posedge clk);
    busB.writeStrobeN <= 1'b0;
    busB.addr <= a;
    busB.wdata <= d;
    busB.outEnableN <= oe;
    @(posedge clk) busB.writeStrobeN <= 1'b1;
    @(posedge clk);
    busB.outEnableN <= 1'b1;
    busB.addr <= ~a;
    busB.wdata <= ~d;
  endtask
  task pre(input logic [`FWU_ADDR_W-1:0] hi, input logic [7:0] c);
    wr(hi | 22'h005555, 8'hAA, 1'b1);
    wr(hi | 22'h002AAA, 8'h55, 1'b1);
    wr(hi | 22'h005555, c, 1'b1);
  endtask
  task t_program;
    int n0;
    int r0;
    n0 = ops;
    r0 = rds;
    cmd(CMD_PROGRAM, 22'h3ABCDE, 8'h5A);
    chk(ops, n0 + 1);
    chk(opKind, OP_PROGRAM);
    chk(opAddr, 22'h3ABCDE);
    chk(opData, 8'h5A);
    cmd(CMD_READ, 22'h3ABCDE, 8'h00);
    chk(rdDoneData, {1'b1, 1'b0, arrayRdData[5:0]});
    chk(rds, r0 + 1);
    chk(arrayAddr, 22'h3ABCDE);
    cmd(CMD_READ, 22'h3ABCDE, 8'h00);
    chk(rdDoneData, {1'b1, 1'b1, arrayRdData[5:0]});
    cmd(CMD_PROGRAM, 22'h000010, 8'h11);
    chk(ops, n0 + 1);
    done;
    chk(busy, 1'b0);
    cmd(CMD_READ, 22'h3ABCDE, 8'h00);
    chk(rdDoneData, arrayRdData);
  endtask
  task t_erase;
    fwu_cmd_t k[3] = '{CMD_SECTOR, CMD_BLOCK, CMD_CHIP};
    fwu_op_t o[3] = '{OP_SECTOR, OP_BLOCK, OP_CHIP};
    logic [7:0] c[3] = '{8'h30, 8'h50, 8'h10};
    logic [`FWU_ADDR_W-1:0] a[3] = '{22'h1F3000, 22'h250000, 22'h005555};
    int n0;
    @(posedge clk) parallelMode <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      n0 = ops;
      cmd(k[i], a[i], c[i]);
      chk(ops, n0 + 1);
      chk(opKind, o[i]);
      chk(opAddr, a[i]);
      chk(opData, c[i]);
      cmd(CMD_READ, a[i], 8'h00);
      chk(rdDoneData[7], 1'b0);
      done;
    end
    @(posedge clk) parallelMode <= 1'b0;
    n0 = ops;
    cmd(CMD_CHIP, 22'h005555, 8'h10);
    chk(ops, n0);
  endtask
  task t_id;
    cmd(CMD_ID_ENTRY, 22'h000000, 8'h90);
    chk(idMode, 1'b1);
    cmd(CMD_READ, 22'h000000, 8'h00);
    chk(rdDoneData, MFR);
    cmd(CMD_READ, 22'h000001, 8'h00);
    chk(rdDoneData, DEV);
    cmd(CMD_ID_EXIT_SHORT, 22'h012345, 8'hF0);
    chk(idMode, 1'b0);
    cmd(CMD_ID_ENTRY, 22'h000000, 8'h90);
    chk(idMode, 1'b1);
    cmd(CMD_ID_EXIT, 22'h000000, 8'hF0);
    chk(idMode, 1'b0);
    cmd(CMD_ID_ENTRY, 22'h000000, 8'h90);
    chk(idMode, 1'b1);
    do_reset;
    chk(idMode, 1'b0);
  endtask
  task t_guard;
    int n0;
    n0 = opsB;
    wr(22'h005555, 8'hA0, 1'b1);
    wr(22'h000100, 8'h77, 1'b1);
    wr(22'h005555, 8'hAA, 1'b1);
    wr(22'h002AAB, 8'h55, 1'b1);
    wr(22'h005555, 8'hA0, 1'b1);
    wr(22'h000100, 8'h77, 1'b1);
    repeat (3) @(negedge clk);
    chk(opsB, n0);
    pre(22'h000000, 8'hA0);
    wr(22'h000100, 8'h77, 1'b0);
    repeat (3) @(negedge clk);
    chk(opsB, n0);
    do_reset;
    pre(22'h3F8000, 8'hA0);
    wr(22'h3F8123, 8'h99, 1'b1);
    repeat (3) @(negedge clk);
    chk(opsB, n0 + 1);
    done;
    @(posedge clk) parallelMode <= 1'b1;
    wr(22'h005555, 8'hAA, 1'b1);
    wr(22'h002AAA, 8'h55, 1'b1);
    @(posedge clk) busB.rdReq <= 1'b1;
    @(posedge clk) busB.rdReq <= 1'b0;
    wr(22'h005555, 8'hA0, 1'b1);
    wr(22'h000200, 8'h66, 1'b1);
    repeat (3) @(negedge clk);
    chk(opsB, n0 + 1);
  endtask
  initial begin
    busB.writeStrobeN = 1'b1;
    busB.outEnableN = 1'b1;
    busB.addr = '0;
    busB.wdata = 8'h00;
    busB.rdReq = 1'b0;
    do_reset;
    t_program;
    t_erase;
    t_id;
    t_guard;
    end_of_test;
  end
  initial begin
    #100000;
    fails++;
    end_of_test;
  end
endmodule
